// ---- core/plcb_pkg.sv ----
package plcb_pkg;

  // ****************************************
  // register map (printed offsets are indices)
  // ****************************************
  localparam logic [7:0]  REG_IDX_CTRL_ONE   = 8'h09;
  localparam logic [7:0]  REG_IDX_CTRL_TWO   = 8'h0a;
  localparam logic [7:0]  REG_IDX_CTRL_THREE = 8'h0b;
  localparam logic [7:0]  REG_IDX_STATUS     = 8'h0c;
  localparam logic [1:0]  ADDR_LSB           = 2'h2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int C1_FAST_MDIX   = 6;
  localparam int C1_ROBUST_MDIX = 5;
  localparam int C2_FAST_PD     = 6;
  localparam int C2_EXT_FD      = 5;
  localparam int C2_ENH_LED     = 4;
  localparam int C2_ISO_MII     = 3;
  localparam int C2_IDLE_ERR    = 2;
  localparam int C2_ODD_DIS     = 1;
  localparam int C2_RMII_RXCLK  = 0;
  localparam int C3_EQ_BYPASS   = 12;
  localparam int C3_DSCR_DROP   = 10;
  localparam int C3_FLD_LO      = 0;
  localparam int C3_FLD_HI      = 3;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [15:0] CTRL_ONE_RST   = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RST   = 16'h0100;
  localparam logic [15:0] CTRL_THREE_RST = 16'h1000;
  localparam logic [15:0] CTRL_ONE_MASK  = 16'hffff;
  localparam logic [15:0] CTRL_TWO_MASK  = 16'hfffe;
  localparam logic [15:0] CTRL_THREE_MASK= 16'hf7ff;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [1:0] {
    PLCB_SPD_NONE  = 2'h0,
    PLCB_SPD_10    = 2'h1,
    PLCB_SPD_100TX = 2'h3
  } plcb_speed_e;

  typedef struct packed {
    logic        link_up;
    plcb_speed_e speed;
    logic        an_or_force_100;
    logic        partner_forced_100;
    logic        ieee_full_duplex;
    logic        activity;
    logic        eq_error;
    logic        dscr_lock_lost;
    logic [3:0]  other_drop;
  } plcb_link_s;

  typedef struct packed {
    logic       link_up;
    logic       full_duplex;
    logic       fast_pd_link;
    logic       mii_isolate;
    logic       led_link;
    logic       rmii_ref_rxclk;
    logic       link_drop;
  } plcb_status_s;

endpackage : plcb_pkg

// ---- core/plcb_ctrl.sv ----
// Summary of operation
// - fast control bit set selects shortened parallel-detect link-up time.
// - fast or robust crossover mode in control one forces fast link-up bit.
// - extended duplex on: partner forced 100TX with us AN/forced 100TX is full.
// - extended duplex off: duplex follows the standard resolution only.
// - enhanced LED lights only for 100TX full duplex; else any link.
// - enhanced LED mode suppresses activity blinking.
// - isolate enabled: receive error output held low in 100TX half or any 10 link.
// - idle-error bit enables reporting of receive symbol errors in IDLE.
// - odd-nibble detection on by default; bit set turns it off.
// - odd nibble adds one transmit enable clock after a one-clock gap, flagged as error.
// - RMII receive data referenced to RX_CLK when set, else crystal input.
// - equalizer bypass bit, reset one, ignores equalizer error indication.
// - descrambler drop bit drops link when descrambler loses lock.
// - descrambler drop coexists with the other four fast link-down criteria.
`timescale 1ns/100ps
`default_nettype none

module plcb_ctrl
  import plcb_pkg::*;
(
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // link state from the pma/pcs
  input  wire plcb_pkg::plcb_link_s link_in,
  // mii transmit side from the mac
  input  wire logic               tx_en_in,
  input  wire logic               tx_er_in,
  input  wire logic               tx_nibble_odd,
  // receive symbol error
  input  wire logic               rx_sym_err,
  input  wire logic               rx_idle,
  input  wire logic               rx_dv_in,
  // outputs
  output logic                    tx_en_out,
  output logic                    tx_er_out,
  output logic                    rx_er_out,
  output logic                    led_link,
  output plcb_pkg::plcb_status_s  status
);
  import plcb_pkg::*;

  // ****************************************
  // input synchronisers (link state is from pins/other logic)
  // ****************************************
  plcb_link_s link_s1_q;
  plcb_link_s link_q;
  logic [2:0] txr_s1_q;
  logic [2:0] txr_q;
  logic [2:0] rx_s1_q;
  logic [2:0] rx_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_s1_q <= '0;
      link_q    <= '0;
      txr_s1_q  <= '0;
      txr_q     <= '0;
      rx_s1_q   <= '0;
      rx_q      <= '0;
    end else begin
      link_s1_q <= link_in;
      link_q    <= link_s1_q;
      txr_s1_q  <= {tx_en_in, tx_er_in, tx_nibble_odd};
      txr_q     <= txr_s1_q;
      rx_s1_q   <= {rx_sym_err, rx_idle, rx_dv_in};
      rx_q      <= rx_s1_q;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  logic [15:0] ctrl_one_q;
  logic [15:0] ctrl_two_q;
  logic [15:0] ctrl_three_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic        wr_hit;
  logic [15:0] wr_mask;
  logic [7:0]  ar_idx;
  logic [15:0] rd_val;
  logic        rd_hit;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held_q && w_held_q;
  assign wr_mask       = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_hit        = (aw_idx_q == REG_IDX_CTRL_ONE) || (aw_idx_q == REG_IDX_CTRL_TWO)
                      || (aw_idx_q == REG_IDX_CTRL_THREE);
  assign ar_idx        = s_axi_araddr[9:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; bit 6 of control two reads back as the crossover-forced copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_q   <= CTRL_ONE_RST;
      ctrl_two_q   <= CTRL_TWO_RST;
      ctrl_three_q <= CTRL_THREE_RST;
    end else if (wr_go) begin
      if (aw_idx_q == REG_IDX_CTRL_ONE)
        ctrl_one_q <= (ctrl_one_q & ~(wr_mask & CTRL_ONE_MASK))
                    | (w_data_q[15:0] & wr_mask & CTRL_ONE_MASK);
      if (aw_idx_q == REG_IDX_CTRL_TWO)
        ctrl_two_q <= (ctrl_two_q & ~wr_mask) | (w_data_q[15:0] & wr_mask);
      if (aw_idx_q == REG_IDX_CTRL_THREE)
        ctrl_three_q <= (ctrl_three_q & ~(wr_mask & CTRL_THREE_MASK))
                      | (w_data_q[15:0] & wr_mask & CTRL_THREE_MASK);
    end
  end

  // crossover modes hold the fast link-up bit at one
  logic fast_pd_eff;
  assign fast_pd_eff = ctrl_two_q[C2_FAST_PD] | ctrl_one_q[C1_FAST_MDIX]
                     | ctrl_one_q[C1_ROBUST_MDIX];

  logic [15:0] ctrl_two_rd;
  always_comb begin
    ctrl_two_rd              = ctrl_two_q;
    ctrl_two_rd[C2_FAST_PD]  = fast_pd_eff;
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_idx)
      REG_IDX_CTRL_ONE:   rd_val = ctrl_one_q;
      REG_IDX_CTRL_TWO:   rd_val = ctrl_two_rd;
      REG_IDX_CTRL_THREE: rd_val = ctrl_three_q;
      REG_IDX_STATUS:     rd_val = {9'h000, status};
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // link resolution
  // ****************************************
  logic is_100tx;
  logic is_10;
  logic full_duplex;
  logic drop_req;

  assign is_100tx = link_q.link_up && (link_q.speed == PLCB_SPD_100TX);
  assign is_10    = link_q.link_up && (link_q.speed == PLCB_SPD_10);

  always_comb begin
    full_duplex = link_q.ieee_full_duplex;
    if (ctrl_two_q[C2_EXT_FD] && link_q.an_or_force_100 && link_q.partner_forced_100)
      full_duplex = 1'b1;
  end

  // equalizer error counts only while bypass is clear; descrambler loss when enabled
  assign drop_req = (link_q.eq_error && !ctrl_three_q[C3_EQ_BYPASS])
                  || (link_q.dscr_lock_lost && ctrl_three_q[C3_DSCR_DROP])
                  || (|(link_q.other_drop & ctrl_three_q[C3_FLD_HI:C3_FLD_LO]));

  // ****************************************
  // led
  // ****************************************
  // activity blink: toggle on activity, suppressed in enhanced mode
  logic blink_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      blink_q <= 1'b0;
    else
      blink_q <= link_q.activity ? ~blink_q : 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      led_link <= 1'b0;
    else if (ctrl_two_q[C2_ENH_LED])
      led_link <= is_100tx && full_duplex && !drop_req;
    else
      led_link <= link_q.link_up && !drop_req && !blink_q;
  end

  // ****************************************
  // mii isolation and transmit path
  // ****************************************
  logic isolate;
  logic odd_ext_q;
  logic tx_en_prev_q;
  assign isolate = ctrl_two_q[C2_ISO_MII] && ((is_100tx && !full_duplex) || is_10);

  // falling tx enable with an odd nibble count adds one errored cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en_prev_q <= 1'b0;
      odd_ext_q    <= 1'b0;
    end else begin
      tx_en_prev_q <= txr_q[2];
      odd_ext_q    <= tx_en_prev_q && !txr_q[2] && txr_q[0]
                   && !ctrl_two_q[C2_ODD_DIS];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en_out <= 1'b0;
      tx_er_out <= 1'b0;
    end else begin
      tx_en_out <= txr_q[2] || odd_ext_q;
      tx_er_out <= (txr_q[2] && txr_q[1]) || odd_ext_q;
    end
  end

  // receive error: idle-state symbol errors only when enabled; held low while isolated (transmit outputs unaffected)
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_er_out <= 1'b0;
    else if (isolate)
      rx_er_out <= 1'b0;
    else
      rx_er_out <= rx_q[2] && (rx_q[0] || (rx_q[1] && ctrl_two_q[C2_IDLE_ERR]));
  end

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn)
      status <= '0;
    else begin
      status.link_up        <= link_q.link_up && !drop_req;
      status.full_duplex    <= full_duplex;
      status.fast_pd_link   <= fast_pd_eff;
      status.mii_isolate    <= isolate;
      status.led_link       <= led_link;
      status.rmii_ref_rxclk <= ctrl_two_q[C2_RMII_RXCLK];
      status.link_drop      <= drop_req;
    end
  end

endmodule // plcb_ctrl
`default_nettype wire

// ---- dv/plcb_ctrl_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module plcb_ctrl_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // outputs
  input wire logic        tx_en_out,
  input wire logic        tx_er_out,
  input wire logic        led_link,
  input wire plcb_pkg::plcb_status_s status
);
  import plcb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // upper address bits left out: how wide the decode is was the designer's call
  logic unmapped;
  assign unmapped = s_axi_araddr[31:8] == 24'h0 && !(s_axi_araddr[7:2] inside {
    REG_IDX_CTRL_ONE[5:0], REG_IDX_CTRL_TWO[5:0], REG_IDX_CTRL_THREE[5:0], REG_IDX_STATUS[5:0]});
  // ****
  // properties
  // ****
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_unmapped_err: assert property (s_rd_take ##0 unmapped |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_led_needs_link: assert property (led_link |-> status.link_up)
    else $error("led lit without link");
  a_iso_needs_link: assert property (status.mii_isolate |-> status.link_up)
    else $error("mii isolated without link");
  a_er_with_en: assert property (tx_er_out |-> tx_en_out)
    else $error("transmit error outside enable");
endmodule // plcb_ctrl_properties

bind plcb_ctrl plcb_ctrl_properties u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .tx_en_out, .tx_er_out, .led_link, .status
);
`default_nettype wire

// ---- dv/plcb_mac_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module plcb_mac_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // frame request
  input  wire logic       start,
  input  wire logic       odd_end,
  input  wire logic [3:0] len,
  // mii transmit
  output logic            tx_en,
  output logic            tx_er,
  output logic            nibble_odd
);
  logic [3:0] left_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q <= 4'h0;
    end else if (start && left_q == 4'h0) begin
      left_q <= len;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  assign tx_en = left_q != 4'h0;
  assign tx_er = 1'b0;
  // odd flag held as a level so its sampling moment does not matter
  assign nibble_odd = odd_end;
endmodule // plcb_mac_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import plcb_pkg::*;
  logic         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         rx_sym_err = 1'b0, rx_idle = 1'b0, rx_dv_in = 1'b0, mac_go = 1'b0;
  logic         mac_odd = 1'b0, tx_en_in, tx_er_in, tx_nibble_odd;
  logic         tx_en_out, tx_er_out, rx_er_out, led_link;
  logic [31:0]  s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [31:0]  rs = 32'h1b;
  logic [3:0]   s_axi_wstrb = 4'hf, mac_len = 4'h4;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rr;
  plcb_link_s   link_in = '0;
  plcb_status_s status;
  int           fails = 0, check_count = 0, cyc = 0, en_cnt = 0, er_cnt = 0;
  localparam logic [15:0] C2_DEF = 16'h0100;
  localparam logic [15:0] RST_TAB [4] = '{16'h0000, C2_DEF, 16'h1000, 16'h0000};
  // control three, equalizer error, lock lost, expected drop
  localparam logic [18:0] T3 [4] = '{{16'h1000, 3'b100}, {16'h1400, 3'b011},
                                     {16'h1000, 3'b010}, {16'h140f, 3'b011}};

  plcb_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_in, .tx_en_in, .tx_er_in, .tx_nibble_odd,
    .rx_sym_err, .rx_idle, .rx_dv_in, .tx_en_out, .tx_er_out, .rx_er_out, .led_link, .status);
  plcb_mac_model u_mac (.aclk, .aresetn, .start(mac_go), .odd_end(mac_odd), .len(mac_len),
    .tx_en(tx_en_in), .tx_er(tx_er_in), .nibble_odd(tx_nibble_odd));

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    en_cnt += tx_en_out;
    er_cnt += tx_er_out;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic exp_fd(input logic ext, input plcb_link_s l);
    return l.ieee_full_duplex | (ext & l.an_or_force_100 & l.partner_forced_100);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is raised only after valid shows, so every response stands a cycle unanswered
  task automatic axi_wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk("bresp", e, s_axi_bresp);
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask
  task automatic results();
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] d, r;
    logic [15:0] c2;
    plcb_link_s  lk;
    logic        fd;
    int          lows;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axi_rd(32'h24 + 4 * i, d);
      chk("reset_value", {16'h0, RST_TAB[i]}, d);
    end
    axi_rd(32'h3c, d);
    chk("unmapped_resp", RESP_SLVERR, rr);
    chk("unmapped_data", 32'h0, d);
    axi_wr(32'h3c, 16'h0001, RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      axi_wr(32'h24, i ? 16'h0020 : 16'h0040, RESP_OKAY);
      axi_rd(32'h28, d);
      chk("auto_fast_pd", 32'h1, d[6]);
    end
    axi_wr(32'h24, 16'h0000, RESP_OKAY);
    axi_wr(32'h28, 16'hffff, RESP_OKAY);
    axi_rd(32'h28, d);
    chk("ctrl_two_rw", 32'hffff, d);
    axi_wr(32'h2c, 16'hffff, RESP_OKAY);
    axi_rd(32'h2c, d);
    chk("ctrl_three_rw", 32'hf7ff, d);
    axi_wr(32'h28, C2_DEF, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      axi_wr(32'h2c, T3[i][18:3], RESP_OKAY);
      lk = '0;
      lk.link_up = 1'b1;
      lk.speed = PLCB_SPD_100TX;
      lk.eq_error = T3[i][2];
      lk.dscr_lock_lost = T3[i][1];
      lk.other_drop = 4'h1;
      link_in <= lk;
      settle();
      chk("link_drop", T3[i][0], status.link_drop);
      chk("link_up", !T3[i][0], status.link_up);
    end
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      lk = '0;
      lk.link_up = 1'b1;
      lk.speed = r[8] ? PLCB_SPD_100TX : PLCB_SPD_10;
      lk.an_or_force_100 = r[9];
      lk.partner_forced_100 = r[10] & r[8];
      lk.ieee_full_duplex = r[11];
      link_in <= lk;
      c2 = C2_DEF | 16'(r[6:0]);
      axi_wr(32'h28, c2, RESP_OKAY);
      axi_rd(32'h28, d);
      chk("ctrl_two", {16'h0, c2}, d);
      settle();
      fd = exp_fd(c2[5], lk);
      chk("full_duplex", fd, status.full_duplex);
      chk("led_link", !c2[4] | (r[8] & fd), led_link);
      chk("mii_isolate", c2[3] & (!r[8] | !fd), status.mii_isolate);
      chk("fast_pd_link", c2[6], status.fast_pd_link);
      chk("rmii_ref", c2[0], status.rmii_ref_rxclk);
    end
    lk = '0;
    lk.link_up = 1'b1;
    lk.speed = PLCB_SPD_100TX;
    lk.ieee_full_duplex = 1'b1;
    lk.activity = 1'b1;
    link_in <= lk;
    for (int e = 0; e < 2; e++) begin
      axi_wr(32'h28, C2_DEF | 16'(e << 4), RESP_OKAY);
      settle();
      lows = 0;
      repeat (8) begin
        @(posedge aclk);
        lows += !led_link;
      end
      chk("led_blink", e ? 0 : 1, lows != 0);
    end
    rx_idle <= 1'b1;
    rx_sym_err <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      axi_wr(32'h28, C2_DEF | 16'(b << 2), RESP_OKAY);
      settle();
      chk("idle_sym_err", b, rx_er_out);
    end
    rx_sym_err <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      axi_wr(32'h28, C2_DEF | 16'(b << 1), RESP_OKAY);
      en_cnt = 0;
      er_cnt = 0;
      mac_odd <= 1'b1;
      mac_go <= 1'b1;
      @(posedge aclk);
      mac_go <= 1'b0;
      repeat (20) @(posedge aclk);
      chk("tx_en_cycles", 5 - b, en_cnt);
      chk("tx_er_cycles", 1 - b, er_cnt);
    end
    results();
  end
endmodule // tb_top
`default_nettype wire
